// file: hdl/pll_lock_monitor.sv
// Lock monitor: synchronisers, lock gating, events, counter and registers
`timescale 1ns/10ps
`include "pll_lock_params.svh"
module pll_lock_monitor
    import pll_lock_pkg::*;
#(
    parameter int unsigned LOCK_MID_CYCLES  = `DEB_MID_CYCLES,
    parameter int unsigned LOCK_LONG_CYCLES = `DEB_LONG_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Analog loop indications, asynchronous to clk_in
    input  wire logic        precision_lock_in,
    input  wire logic        original_lock_in,
    input  wire logic        rail_high_in,
    input  wire logic        rail_low_in,
    input  wire logic        cal_done_in,
    input  wire logic        cal_fail_in,
    input  wire logic [5:0]  vco_band_in,
    // Register port
    input  wire logic [2:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] reg_wdata_in,
    output logic      [15:0] reg_rdata_out,
    // Outputs to the analog loop and the status pin
    output logic             lock_pin_out,
    output logic             lock_out,
    output logic             detector_enable_out,
    output logic             precision_enable_out,
    output logic [3:0]       fine_lock_upper_threshold_out,
    output logic [3:0]       fine_lock_lower_threshold_out,
    output logic [2:0]       detect_filter_sel_out
);

    // ======================================================================
    // Declarations
    monitor_state_t     state;
    monitor_state_t     next_state;
    logic [`SYNC_W-1:0] raw_inputs;
    logic [`SYNC_W-1:0] agree;
    logic               debounced;
    logic               raw_selected;
    logic               bypass;
    logic               next_lock_rt;
    logic               lock_fall;
    logic [3:0]         cnt_base;
    logic               wr_cfg;
    logic               wr_thr;
    logic               wr_evt;
    logic               wr_cnt;

    // ======================================================================
    // Address decode, shared by write and read paths
    function automatic logic hit(input logic [2:0] addr, input logic [2:0] idx);
        hit = (addr == idx);
    endfunction : hit

    assign raw_inputs = {vco_band_in, cal_fail_in, cal_done_in, rail_low_in,
                         rail_high_in, original_lock_in, precision_lock_in};

    // A bit changes only when second and third stage agree
    genvar g;
    generate
        for (g = 0; g < `SYNC_W; g++) begin : g_agree
            assign agree[g] = ~(state.sync2[g] ^ state.sync3[g]);
        end
    endgenerate

    // ======================================================================
    // Lock gating
    assign bypass       = state.cfg[`CFG_BYPASS];
    assign raw_selected = state.cfg[`CFG_FINE_EN] ? state.clean[`SYN_PRECISION]
                                                  : state.clean[`SYN_ORIGINAL]; // R2

    lock_debounce #(
        .SHORT_CYCLES (`DEB_SHORT_CYCLES),
        .MID_CYCLES   (LOCK_MID_CYCLES),
        .LONG_CYCLES  (LOCK_LONG_CYCLES)
    ) u_debounce (
        .clk_in           (clk_in),
        .rst_n_in         (rst_n_in),
        .raw_in           (state.det_en & raw_selected),
        .interval_code_in (state.cfg[`CFG_TIMER_HI:`CFG_TIMER_LO]), // R3
        .stable_out       (debounced)
    );

    assign next_lock_rt = bypass | debounced; // R6 R10
    assign lock_fall    = state.lock_rt & ~next_lock_rt; // R13 R15

    assign wr_cfg = reg_wr_in && hit(reg_addr_in, `REG_LOCK_CFG);
    assign wr_thr = reg_wr_in && hit(reg_addr_in, `REG_LOCK_THR);
    assign wr_evt = reg_wr_in && hit(reg_addr_in, `REG_EVENTS);
    assign wr_cnt = reg_wr_in && hit(reg_addr_in, `REG_LOSS_CNT);

    // A write that meets a fall still counts the fall
    assign cnt_base = wr_cnt ? reg_wdata_in[3:0] : state.loss_cnt; // R16

    // ======================================================================
    // Next state
    always_comb begin
        next_state = state;

        next_state.sync1 = raw_inputs;
        next_state.sync2 = state.sync1;
        next_state.sync3 = state.sync2;
        next_state.clean = (agree & state.sync3) | (~agree & state.clean);

        if (wr_cfg) begin
            next_state.cfg = reg_wdata_in & `CFG_USED_MASK;
        end
        if (wr_thr) begin
            next_state.thr = reg_wdata_in[7:0];
        end

        // Detector waits for calibration unless told to run throughout
        next_state.det_en = ~bypass & (state.cfg[`CFG_CAL_DETECT] |
                                       state.clean[`SYN_CAL_DONE]); // R5 R6

        next_state.lock_rt = next_lock_rt;

        if (!state.cfg[`CFG_STICKY]) begin
            next_state.held = 1'b0; // R4
        end else if (next_lock_rt) begin
            next_state.held = 1'b1; // R4
        end
        next_state.indication = next_lock_rt |
                                (state.cfg[`CFG_STICKY] & state.held); // R4 R6

        next_state.lock_pin = state.cfg[`CFG_RAW_PIN] ? raw_selected
                                                      : next_state.indication; // R1

        // Set wins over a simultaneous write-one clear
        next_state.events = state.events;
        if (wr_evt) begin
            next_state.events = state.events & ~reg_wdata_in[2:0]; // R14
        end
        if (state.clean[`SYN_RAIL_HIGH]) begin
            next_state.events[`STS_RAIL_HIGH] = 1'b1; // R12
        end
        if (state.clean[`SYN_RAIL_LOW]) begin
            next_state.events[`STS_RAIL_LOW] = 1'b1; // R12
        end
        if (lock_fall) begin
            next_state.events[`STS_LOCK] = 1'b1; // R13
        end

        next_state.loss_cnt = cnt_base;
        if (lock_fall && cnt_base != `LOSS_CNT_MAX) begin
            next_state.loss_cnt = cnt_base + 4'h1; // R15
        end

        // Read data is registered; unmapped reads give zero
        if (!reg_rd_in) begin
            next_state.rdata = state.rdata;
        end else if (hit(reg_addr_in, `REG_LOCK_CFG)) begin
            next_state.rdata = state.cfg;
        end else if (hit(reg_addr_in, `REG_LOCK_THR)) begin
            next_state.rdata = {8'h00, state.thr};
        end else if (hit(reg_addr_in, `REG_CAL_STS)) begin
            next_state.rdata = {8'h00, state.clean[`SYN_CAL_FAIL],
                                state.clean[`SYN_CAL_DONE],
                                state.clean[`SYN_BAND_HI:`SYN_BAND_LO]}; // R7 R8 R9
        end else if (hit(reg_addr_in, `REG_LOCK_STS)) begin
            next_state.rdata = {13'h0000, state.clean[`SYN_RAIL_HIGH],
                                state.clean[`SYN_RAIL_LOW], state.lock_rt}; // R10 R11
        end else if (hit(reg_addr_in, `REG_EVENTS)) begin
            next_state.rdata = {13'h0000, state.events & `EVT_MASK};
        end else if (hit(reg_addr_in, `REG_LOSS_CNT)) begin
            next_state.rdata = {12'h000, state.loss_cnt};
        end else begin
            next_state.rdata = 16'h0000;
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state     <= '0;
            state.cfg <= `LOCK_CFG_RESET;
            state.thr <= `LOCK_THR_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================================
    // Outputs, all straight from flops
    assign reg_rdata_out                 = state.rdata;
    assign lock_pin_out                  = state.lock_pin;
    assign lock_out                      = state.indication;
    assign detector_enable_out           = state.det_en;
    assign precision_enable_out          = state.cfg[`CFG_FINE_EN];
    assign fine_lock_upper_threshold_out = state.thr[7:4];
    assign fine_lock_lower_threshold_out = state.thr[3:0];
    assign detect_filter_sel_out         = state.cfg[`CFG_FILT_HI:`CFG_FILT_LO];

endmodule : pll_lock_monitor

// file: hdl/pll_lock_params.svh
// Offsets, field positions, reset values and counts for the lock monitor
// Operation
// (R1) Raw-to-pin bit routes undebounced lock to pin
// (R2) Fine enable selects the precision threshold detector
// (R3) Two-bit code picks debounce interval length
// (R4) Sticky select holds indication after first lock
// (R5) Detector runs after calibration unless option set
// (R6) Bypass disables detector and forces lock asserted
// (R7) Calibration done flag reports calibration progress
// (R8) Calibration fail flag reports failure outcome
// (R9) Six-bit calibrated band is read only
// (R10) Real-time lock status bit is read only
// (R11) Real-time rail high and low bits
// (R12) Rail statuses set sticky rail event flags
// (R13) Locked to unlocked sets loss-of-lock flag
// (R14) Event flags clear by writing one only
// (R15) Four-bit loss counter increments and saturates
// (R16) Counter write loads value, counting continues
// (R17) Lock asserts after continuous interval, restarts otherwise
`ifndef PLL_LOCK_PARAMS_SVH
`define PLL_LOCK_PARAMS_SVH

// ==========================================================================
// Register indexes
`define REG_LOCK_CFG        3'h0
`define REG_LOCK_THR        3'h1
`define REG_CAL_STS         3'h2
`define REG_LOCK_STS        3'h3
`define REG_EVENTS          3'h4
`define REG_LOSS_CNT        3'h5

// ==========================================================================
// Lock detect configuration fields
`define CFG_RAW_PIN         9
`define CFG_FINE_EN         8
`define CFG_TIMER_HI        7
`define CFG_TIMER_LO        6
`define CFG_STICKY          5
`define CFG_CAL_DETECT      4
`define CFG_BYPASS          3
`define CFG_FILT_HI         2
`define CFG_FILT_LO         0
`define CFG_USED_MASK       16'h03ff
`define LOCK_CFG_RESET      16'h0180
`define LOCK_THR_RESET      8'h88

// ==========================================================================
// Status and event bit positions
`define STS_RAIL_HIGH       2
`define STS_RAIL_LOW        1
`define STS_LOCK            0
`define EVT_MASK            3'h7
`define LOSS_CNT_MAX        4'hf

// ==========================================================================
// Synchroniser vector layout
`define SYNC_W              12
`define SYN_PRECISION       0
`define SYN_ORIGINAL        1
`define SYN_RAIL_HIGH       2
`define SYN_RAIL_LOW        3
`define SYN_CAL_DONE        4
`define SYN_CAL_FAIL        5
`define SYN_BAND_LO         6
`define SYN_BAND_HI         11

// ==========================================================================
// Debounce counts in system clock cycles
`define DEB_CNT_W           16
`define DEB_SHORT_CYCLES    570
`define DEB_MID_CYCLES      5700
`define DEB_LONG_CYCLES     57000
`define DEB_CODE_NONE       2'h0
`define DEB_CODE_SHORT      2'h1
`define DEB_CODE_MID        2'h2

`endif

// file: hdl/pll_lock_pkg.sv
// State types of the lock monitor and its debouncer
`include "pll_lock_params.svh"
package pll_lock_pkg;

    typedef struct packed {
        logic [`DEB_CNT_W-1:0] count;
        logic                  stable;
    } debounce_state_t;

    typedef struct packed {
        logic [`SYNC_W-1:0] sync1;
        logic [`SYNC_W-1:0] sync2;
        logic [`SYNC_W-1:0] sync3;
        logic [`SYNC_W-1:0] clean;
        logic [15:0]        cfg;
        logic [7:0]         thr;
        logic [2:0]         events;
        logic [3:0]         loss_cnt;
        logic               det_en;
        logic               lock_rt;
        logic               held;
        logic               indication;
        logic               lock_pin;
        logic [15:0]        rdata;
    } monitor_state_t;

endpackage : pll_lock_pkg

// file: hdl/lock_debounce.sv
// Debounce counter for the gated lock signal
`timescale 1ns/10ps
`include "pll_lock_params.svh"
module lock_debounce
    import pll_lock_pkg::*;
#(
    parameter int unsigned SHORT_CYCLES = `DEB_SHORT_CYCLES,
    parameter int unsigned MID_CYCLES   = `DEB_MID_CYCLES,
    parameter int unsigned LONG_CYCLES  = `DEB_LONG_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       raw_in,
    input  wire logic [1:0] interval_code_in,
    output logic            stable_out
);

    debounce_state_t            state;
    debounce_state_t            next_state;
    logic [`DEB_CNT_W-1:0]      target;

    always_comb begin
        case (interval_code_in)
            `DEB_CODE_SHORT: target = `DEB_CNT_W'(SHORT_CYCLES);
            `DEB_CODE_MID:   target = `DEB_CNT_W'(MID_CYCLES);
            default:         target = `DEB_CNT_W'(LONG_CYCLES);
        endcase
    end

    always_comb begin
        next_state = state;
        if (!raw_in) begin
            // Any drop restarts the whole interval
            next_state.count  = '0; // R17
            next_state.stable = 1'b0;
        end else if (interval_code_in == `DEB_CODE_NONE) begin
            next_state.stable = 1'b1; // R3
        end else if (!state.stable) begin
            next_state.count  = state.count + `DEB_CNT_W'(1);
            next_state.stable = (next_state.count >= target); // R3 R17
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign stable_out = state.stable;

endmodule : lock_debounce

// file: tb/lock_monitor_monitor.sv
// Port-level assertions for the lock monitor
`timescale 1ns/10ps
module lock_monitor_checker #(
    parameter int unsigned LOCK_MID_CYCLES  = 5700,
    parameter int unsigned LOCK_LONG_CYCLES = 57000
) (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [2:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        lock_out,
    input wire logic        detector_enable_out,
    input wire logic        precision_enable_out,
    input wire logic [3:0]  fine_lock_upper_threshold_out,
    input wire logic [3:0]  fine_lock_lower_threshold_out,
    input wire logic [2:0]  detect_filter_sel_out
);
    // ==========================================================================
    // Helper state
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [15:0] wd_q;
    logic [3:0]  cnt_wr;
    logic        lost;
    logic        sticky_q;
    // Clear wins over a fall seen the same cycle, so the helper never over-claims
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wd_q     <= 16'h0000;
            cnt_wr   <= 4'h0;
            lost     <= 1'b0;
            sticky_q <= 1'b0;
        end else begin
            wd_q <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == 3'h0) sticky_q <= reg_wdata_in[5];
            if (reg_wr_in && reg_addr_in == 3'h5) cnt_wr <= reg_wdata_in[3:0];
            // Dropping sticky mode lowers lock_out with no fresh loss event
            if (reg_wr_in && reg_addr_in == 3'h4 && reg_wdata_in[0]) lost <= 1'b0;
            else if ($fell(lock_out) && !$past(sticky_q, 2)) lost <= 1'b1;
        end
    end
    property p_cfg_write;
        reg_wr_in && reg_addr_in == 3'h0 |=> precision_enable_out == wd_q[8]
            && detect_filter_sel_out == wd_q[2:0];
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write not applied");
    property p_thr_write;
        reg_wr_in && reg_addr_in == 3'h1 |=> {fine_lock_upper_threshold_out,
            fine_lock_lower_threshold_out} == wd_q[7:0];
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold write not applied");
    property p_bypass;
        (reg_wr_in && reg_addr_in == 3'h0 && reg_wdata_in[3]) ##1
            !(reg_wr_in && reg_addr_in == 3'h0) |=> lock_out && !detector_enable_out;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass did not force lock");
    property p_sts_read;
        reg_rd_in && reg_addr_in == 3'h3 |=> reg_rdata_out[15:3] == 13'h0000;
    endproperty
    a_sts_read: assert property (p_sts_read) else $error("status upper bits set");
    property p_loss_evt;
        lost && reg_rd_in && reg_addr_in == 3'h4 |=> reg_rdata_out[0];
    endproperty
    a_loss_evt: assert property (p_loss_evt) else $error("loss event flag missing");
    property p_evt_clear;
        (reg_wr_in && reg_addr_in == 3'h4 && reg_wdata_in[0] && lock_out && !sticky_q)
            ##1 lock_out[*2]
            ##0 (reg_rd_in && reg_addr_in == 3'h4) |=> !reg_rdata_out[0];
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("event flag not cleared");
    property p_cnt_load;
        (reg_wr_in && reg_addr_in == 3'h5 && lock_out && !sticky_q) ##1 lock_out[*2]
            ##0 (reg_rd_in && reg_addr_in == 3'h5) |=> reg_rdata_out == {12'h000, cnt_wr};
    endproperty
    a_cnt_load: assert property (p_cnt_load) else $error("counter load lost");
    property p_unmapped;
        reg_rd_in && reg_addr_in > 3'h5 |=> reg_rdata_out == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : lock_monitor_checker

// file: tb/tb.sv
// Self-checking bench for the lock monitor
`timescale 1ns/10ps
module tb;
    logic        clk_in, rst_n_in, prec, orig, rail_hi, rail_lo, cal_done, cal_fail;
    logic        wr, rd, lock_pin, lock, det_en, prec_en;
    logic [5:0]  band;
    logic [2:0]  addr, filt;
    logic [3:0]  thr_hi, thr_lo;
    logic [15:0] wdata, rdata;
    int          fail_count = 0;
    int          checked = 0;
    pll_lock_monitor #(.LOCK_MID_CYCLES(20), .LOCK_LONG_CYCLES(40)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .precision_lock_in(prec), .original_lock_in(orig),
        .rail_high_in(rail_hi), .rail_low_in(rail_lo), .cal_done_in(cal_done),
        .cal_fail_in(cal_fail), .vco_band_in(band), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .lock_pin_out(lock_pin),
        .lock_out(lock), .detector_enable_out(det_en), .precision_enable_out(prec_en),
        .fine_lock_upper_threshold_out(thr_hi), .fine_lock_lower_threshold_out(thr_lo),
        .detect_filter_sel_out(filt));
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // ==========================================================================
    // Access and compare tasks
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd   <= 1'b0;
        @(posedge clk_in);
        #1;
        cmp(rdata, exp);
    endtask : rd_reg
    // Order: precision, original, rail high, rail low, cal done, cal fail
    task automatic drive(input logic [5:0] v);
        @(posedge clk_in);
        {prec, orig, rail_hi, rail_lo, cal_done, cal_fail} <= v;
    endtask : drive
    // Result packs detector enable, status pin and lock indication
    task automatic chk(input int n, input logic [15:0] exp);
        repeat (n) @(posedge clk_in);
        #1;
        cmp({13'h0000, det_en, lock_pin, lock}, exp);
    endtask : chk
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        close_out();
    end
    // ==========================================================================
    // Test sequence
    initial begin
        rst_n_in = 1'b0;
        {prec, orig, rail_hi, rail_lo, cal_done, cal_fail, wr, rd} = 8'h00;
        {addr, wdata} = 19'h00000;
        band = 6'h2a;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd_reg(3'h0, 16'h0180);
        rd_reg(3'h1, 16'h0088);
        for (int i = 2; i < 7; i++) rd_reg(i[2:0], (i == 2) ? 16'h002a : 16'h0000);
        wr_reg(3'h2, 16'hffff);
        rd_reg(3'h2, 16'h002a);
        wr_reg(3'h1, 16'h003c);
        rd_reg(3'h1, 16'h003c);
        // Pin inputs need four edges through the synchroniser before a read
        drive(6'b000011);
        repeat (4) @(posedge clk_in);
        rd_reg(3'h2, 16'h00ea);
        drive(6'b000010);
        repeat (4) @(posedge clk_in);
        rd_reg(3'h2, 16'h006a);
        drive(6'b001110);
        repeat (4) @(posedge clk_in);
        rd_reg(3'h3, 16'h0006);
        drive(6'b000010);
        repeat (4) @(posedge clk_in);
        rd_reg(3'h3, 16'h0000);
        rd_reg(3'h4, 16'h0006);
        wr_reg(3'h4, 16'h0000);
        rd_reg(3'h4, 16'h0006);
        wr_reg(3'h4, 16'h0002);
        rd_reg(3'h4, 16'h0004);
        wr_reg(3'h4, 16'h0004);
        wr_reg(3'h0, 16'h0180);
        drive(6'b100010);
        chk(12, 16'h0004);
        chk(22, 16'h0007);
        rd_reg(3'h3, 16'h0001);
        drive(6'b000010);
        chk(8, 16'h0004);
        rd_reg(3'h4, 16'h0001);
        rd_reg(3'h5, 16'h0001);
        drive(6'b100010);
        repeat (12) @(posedge clk_in);
        drive(6'b000010);
        repeat (4) @(posedge clk_in);
        drive(6'b100010);
        chk(14, 16'h0004);
        chk(20, 16'h0007);
        wr_reg(3'h0, 16'h0140);
        drive(6'b000010);
        chk(8, 16'h0004);
        drive(6'b100010);
        chk(500, 16'h0004);
        chk(100, 16'h0007);
        wr_reg(3'h0, 16'h02c0);
        chk(10, 16'h0004);
        drive(6'b010010);
        chk(8, 16'h0006);
        chk(45, 16'h0007);
        drive(6'b100010);
        chk(8, 16'h0004);
        wr_reg(3'h0, 16'h0100);
        drive(6'b100000);
        chk(10, 16'h0000);
        wr_reg(3'h0, 16'h0110);
        chk(10, 16'h0007);
        wr_reg(3'h0, 16'h0130);
        drive(6'b000000);
        chk(10, 16'h0007);
        wr_reg(3'h0, 16'h0110);
        chk(6, 16'h0004);
        wr_reg(3'h0, 16'h0008);
        chk(4, 16'h0003);
        rd_reg(3'h5, 16'h0006);
        rd_reg(3'h4, 16'h0001);
        wr_reg(3'h4, 16'h0007);
        rd_reg(3'h4, 16'h0000);
        wr_reg(3'h5, 16'h000e);
        rd_reg(3'h5, 16'h000e);
        for (int i = 0; i < 2; i++) begin
            wr_reg(3'h0, 16'h0110);
            chk(6, 16'h0004);
            wr_reg(3'h0, 16'h0008);
            chk(4, 16'h0003);
        end
        rd_reg(3'h5, 16'h000f);
        wr_reg(3'h5, 16'h0000);
        rd_reg(3'h5, 16'h0000);
        close_out();
    end
endmodule : tb
bind pll_lock_monitor lock_monitor_checker #(.LOCK_MID_CYCLES(LOCK_MID_CYCLES),
    .LOCK_LONG_CYCLES(LOCK_LONG_CYCLES)) u_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .lock_out(lock_out),
    .detector_enable_out(detector_enable_out), .precision_enable_out(precision_enable_out),
    .fine_lock_upper_threshold_out(fine_lock_upper_threshold_out),
    .fine_lock_lower_threshold_out(fine_lock_lower_threshold_out),
    .detect_filter_sel_out(detect_filter_sel_out));
